// ---- core/cusm_pkg.sv ----
// Package: status byte layout, address width, zero constants and states
package cusm_pkg;
    localparam int          STAT_W      = 8;
    localparam int          ADDR_W      = 8;
    localparam int          BIT_ATTN    = 0;
    localparam int          BIT_SMOD    = 1;
    localparam int          BIT_CUEND   = 2;
    localparam int          BIT_BUSY    = 3;
    localparam int          BIT_CHEND   = 4;
    localparam int          BIT_DEVEND  = 5;
    localparam int          BIT_UCHK    = 6;
    localparam int          BIT_UEXC    = 7;
    localparam logic [7:0]  STAT_ZERO   = 8'h00;
    localparam logic [7:0]  ADDR_ZERO   = 8'h00;

    typedef enum logic [3:0] {
        CUSM_IDLE  = 4'h1,
        CUSM_OFFER = 4'h2,
        CUSM_HOLD  = 4'h4,
        CUSM_DONE  = 4'h8
    } cusm_state_e;
endpackage : cusm_pkg

// ---- core/cusm_parity.sv ----
// Odd parity generator for one status byte
module cusm_parity
    import cusm_pkg::*;
#(
    parameter int W = STAT_W
) (
    // Data in
    input  wire logic [W-1:0] data_i,
    // Parity out
    output logic              par_o
);
    // Odd parity: bit set when the byte holds an even number of ones
    assign par_o = ~(^data_i);
endmodule : cusm_parity

// ---- core/cusm_status_ctrl.sv ----
// Control-unit status modifier and control-unit-end logic
module cusm_status_ctrl
    import cusm_pkg::*;
#(
    parameter bit CU_BUSY_CAPABLE = 1'b1,
    parameter bit TIO_CAPABLE     = 1'b1,
    parameter bit ALLOW_OTHER_DEV = 1'b1
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    // Initial selection / short busy from the channel side
    input  wire logic              sel_req_i,
    input  wire logic              sel_tio_i,
    input  wire logic [ADDR_W-1:0] sel_addr_i,
    // Control unit and device conditions
    input  wire logic              cu_busy_i,
    input  wire logic              dev_busy_i,
    input  wire logic              op_active_i,
    input  wire logic [ADDR_W-1:0] op_addr_i,
    input  wire logic              chend_ev_i,
    input  wire logic              devend_ev_i,
    input  wire logic              ready_ev_i,
    input  wire logic              special_end_i,
    input  wire logic              retry_req_i,
    input  wire logic              special_cond_i,
    input  wire logic              unusual_i,
    input  wire logic [ADDR_W-1:0] free_addr_i,
    // Channel acceptance of presented status
    input  wire logic              stat_accept_i,
    // Status towards the channel
    output logic                   stat_valid_o,
    output logic [STAT_W-1:0]      stat_byte_o,
    output logic                   stat_par_o,
    output logic [ADDR_W-1:0]      stat_addr_o,
    output logic                   stat_self_init_o,
    output logic                   chain_sup_o,
    // Control unit state
    output logic                   cuend_pend_o,
    output logic                   sel_allow_o
);
    cusm_state_e       state_ff, nxt_state;
    logic [STAT_W-1:0] stat_ff, nxt_stat;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic              self_ff, nxt_self;
    logic              pend_ff;
    logic              ce_seen_ff;
    logic              par_ff;
    logic              chain_ff;
    logic              allow_ff;
    logic              par_w;

    // Selection answer decode
    wire sel_tio_refuse = sel_req_i & sel_tio_i & ~TIO_CAPABLE;
    wire sel_cu_busy    = sel_req_i & cu_busy_i & CU_BUSY_CAPABLE;
    wire cu_free        = ~cu_busy_i;
    // A busy period ends with the pending flag set: answer owed
    wire cuend_due      = pend_ff & cu_free & CU_BUSY_CAPABLE;
    // Unusual condition counts only once channel end went out
    wire unusual_cu     = unusual_i & cu_busy_i & ce_seen_ff & CU_BUSY_CAPABLE;
    wire op_status      = chend_ev_i | devend_ev_i | ready_ev_i | special_end_i
                          | retry_req_i | special_cond_i;
    wire idle_w         = (state_ff == CUSM_IDLE);

    // Status byte for a self-initiated presentation
    logic [STAT_W-1:0] self_byte;
    always_comb begin
        self_byte = STAT_ZERO;
        self_byte[BIT_CHEND]  = chend_ev_i | retry_req_i;
        self_byte[BIT_DEVEND] = devend_ev_i | ready_ev_i | special_end_i;
        self_byte[BIT_ATTN]   = ready_ev_i;
        self_byte[BIT_UEXC]   = ready_ev_i;
        self_byte[BIT_UCHK]   = retry_req_i | unusual_cu;
        self_byte[BIT_SMOD]   = special_end_i | retry_req_i | special_cond_i;
        self_byte[BIT_CUEND]  = cuend_due | unusual_cu;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_stat  = stat_ff;
        nxt_addr  = addr_ff;
        nxt_self  = self_ff;
        case (state_ff)
            CUSM_IDLE: begin
                if (sel_tio_refuse) begin
                    // Pending status untouched and not reported here
                    nxt_stat  = STAT_ZERO;
                    nxt_stat[BIT_SMOD] = 1'b1;
                    nxt_addr  = sel_addr_i;
                    nxt_self  = 1'b0;
                    nxt_state = CUSM_OFFER;
                end else if (sel_cu_busy) begin
                    nxt_stat  = STAT_ZERO;
                    nxt_stat[BIT_SMOD] = 1'b1;
                    nxt_stat[BIT_BUSY] = 1'b1;
                    nxt_addr  = sel_addr_i;
                    nxt_self  = 1'b0;
                    nxt_state = CUSM_OFFER;
                end else if (sel_req_i & cuend_due) begin
                    // Selection after the busy period: deliver owed CU end
                    nxt_stat  = STAT_ZERO;
                    nxt_stat[BIT_CUEND] = 1'b1;
                    nxt_addr  = sel_addr_i;
                    nxt_self  = 1'b0;
                    nxt_state = CUSM_OFFER;
                end else if (~sel_req_i & (op_status | cuend_due | unusual_cu)) begin
                    // Self-initiated status, taken only when no selection is requested
                    nxt_stat  = self_byte;
                    nxt_addr  = (chend_ev_i | devend_ev_i) ? op_addr_i : free_addr_i;
                    nxt_self  = 1'b1;
                    nxt_state = CUSM_OFFER;
                end
            end
            CUSM_OFFER: begin
                nxt_state = CUSM_HOLD;
            end
            CUSM_HOLD: begin
                if (stat_accept_i) begin
                    nxt_stat  = STAT_ZERO;
                    nxt_state = CUSM_DONE;
                end
            end
            CUSM_DONE: begin
                nxt_state = CUSM_IDLE;
            end
            default: begin
                nxt_state = CUSM_IDLE;
                nxt_stat  = STAT_ZERO;
            end
        endcase
    end

    cusm_parity #(.W(STAT_W)) u_par (
        .data_i (nxt_stat),
        .par_o  (par_w)
    );

    // Accepted CU end, and the busy answer that sets the flag
    wire cuend_taken = (state_ff == CUSM_HOLD) & stat_accept_i & stat_ff[BIT_CUEND];
    wire busy_given  = idle_w & sel_cu_busy & ~sel_tio_refuse;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= CUSM_IDLE;
            stat_ff  <= STAT_ZERO;
            addr_ff  <= ADDR_ZERO;
            self_ff  <= 1'b0;
            par_ff   <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            stat_ff  <= nxt_stat;
            addr_ff  <= nxt_addr;
            self_ff  <= nxt_self;
            par_ff   <= par_w;
        end
    end

    // Set wins over clear so a busy answer in the accept cycle is kept
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_ff <= 1'b0;
        end else if (busy_given) begin
            pend_ff <= 1'b1;
        end else if (cuend_taken) begin
            pend_ff <= 1'b0;
        end
    end

    // Tracks channel end accepted while the operation runs
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ce_seen_ff <= 1'b0;
        end else if ((state_ff == CUSM_HOLD) & stat_accept_i & stat_ff[BIT_CHEND]) begin
            ce_seen_ff <= 1'b1;
        end else if (~op_active_i | cuend_taken) begin
            ce_seen_ff <= 1'b0;
        end
    end

    // Chaining stops whenever CU end or busy is accepted
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chain_ff <= 1'b0;
        end else begin
            chain_ff <= (state_ff == CUSM_HOLD) & stat_accept_i
                        & (stat_ff[BIT_CUEND] | stat_ff[BIT_BUSY]);
        end
    end

    // Other devices may be started while CU end pends, if chosen
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            allow_ff <= 1'b1;
        end else begin
            allow_ff <= ~cu_busy_i & ~dev_busy_i & (~pend_ff | ALLOW_OTHER_DEV);
        end
    end

    assign stat_valid_o     = (state_ff == CUSM_HOLD);
    assign stat_byte_o      = stat_ff;
    assign stat_par_o       = par_ff;
    assign stat_addr_o      = addr_ff;
    assign stat_self_init_o = self_ff;
    assign chain_sup_o      = chain_ff;
    assign cuend_pend_o     = pend_ff;
    assign sel_allow_o      = allow_ff;
endmodule : cusm_status_ctrl

// ---- sim/cusm_status_ctrl_asserts.sv ----
// Checker: status byte, control-unit end and chaining relations
module cusm_status_ctrl_asserts
    import cusm_pkg::*;
(
    // Clock and reset
    input wire logic              clock_i,
    input wire logic              rst_n_i,
    // Channel side
    input wire logic [ADDR_W-1:0] sel_addr_i,
    input wire logic [ADDR_W-1:0] free_addr_i,
    input wire logic              stat_accept_i,
    // Status out
    input wire logic              stat_valid_o,
    input wire logic [STAT_W-1:0] stat_byte_o,
    input wire logic              stat_par_o,
    input wire logic [ADDR_W-1:0] stat_addr_o,
    input wire logic              stat_self_init_o,
    input wire logic              chain_sup_o,
    input wire logic              cuend_pend_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic acc_sup;
    assign acc_sup = stat_valid_o && stat_accept_i && (stat_byte_o[BIT_CUEND] || stat_byte_o[BIT_BUSY]);
    sequence s_acc;
        stat_valid_o && stat_accept_i;
    endsequence
    parity_odd_a: assert property (stat_valid_o |-> ^{stat_byte_o, stat_par_o}) else $error("bad parity");
    stat_stable_a: assert property (stat_valid_o && !stat_accept_i |=> stat_valid_o && $stable(stat_byte_o))
        else $error("status changed before acceptance");
    stat_clear_a: assert property (s_acc |-> ##[1:2] (!stat_valid_o && stat_byte_o == STAT_ZERO))
        else $error("status not cleared");
    ready_attn_a: assert property (stat_valid_o && stat_byte_o[BIT_ATTN] |-> stat_byte_o[BIT_DEVEND]
        && stat_byte_o[BIT_UEXC]) else $error("attention without companions");
    busy_pend_a: assert property (s_acc ##0 (stat_byte_o[BIT_BUSY] && stat_byte_o[BIT_SMOD]) |=> cuend_pend_o)
        else $error("busy response left nothing owed");
    cuend_src_a: assert property ($rose(stat_valid_o) && stat_byte_o[BIT_CUEND] && !stat_byte_o[BIT_UCHK]
        |-> cuend_pend_o) else $error("unowed control-unit end");
    pend_clear_a: assert property (s_acc ##0 (stat_byte_o == 8'h04) |-> ##[1:2] !cuend_pend_o)
        else $error("owed flag not cleared");
    chain_sup_a: assert property (chain_sup_o |-> $past(acc_sup)) else $error("stray chain suppress");
    sel_addr_a: assert property ($rose(stat_valid_o) && !stat_self_init_o |-> stat_addr_o == $past(sel_addr_i, 2))
        else $error("selection address not echoed");
    lone_addr_a: assert property ($rose(stat_valid_o) && stat_self_init_o && stat_byte_o == 8'h04
        |-> stat_addr_o == $past(free_addr_i, 2)) else $error("lone end address wrong");
endmodule : cusm_status_ctrl_asserts

bind cusm_status_ctrl cusm_status_ctrl_asserts u_chk (.*);

// ---- sim/cusm_chan_model.sv ----
// Channel model: accepts presented status after a chosen delay
module cusm_chan_model (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       stat_valid_i,
    input  wire logic [7:0] stat_byte_i,
    input  wire logic [7:0] stat_addr_i,
    input  wire logic       stat_self_i,
    input  wire logic [3:0] delay_i,
    output logic            accept_o,
    output logic            got_o,
    output logic [7:0]      got_byte_o,
    output logic [7:0]      got_addr_o,
    output logic            got_self_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_ff;
    logic       wait_low_ff;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {cnt_ff, wait_low_ff, accept_o, got_o} <= '0;
        end else begin
            accept_o <= 1'b0;
            got_o    <= accept_o;
            if (accept_o) begin
                // Capture at the accepting edge; chaining stops on CU end or busy
                {got_byte_o, got_addr_o, got_self_o} <= {stat_byte_i, stat_addr_i, stat_self_i};
                wait_low_ff <= 1'b1;
                cnt_ff      <= 4'h0;
            end else if (wait_low_ff) begin
                wait_low_ff <= stat_valid_i; // One acceptance per status byte
            end else if (stat_valid_i) begin
                accept_o <= (cnt_ff >= delay_i);
                cnt_ff   <= cnt_ff + 4'h1;
            end
        end
    end
endmodule : cusm_chan_model

// ---- sim/cusm_status_ctrl_tb.sv ----
// Testbench: status modifier and control-unit end scenarios
module cusm_status_ctrl_tb
    import cusm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i, rst_n_i, sel_req_i, cu_busy_i, dev_busy_i, ready_ev_i, special_end_i, retry_req_i;
    logic special_cond_i, stat_accept_i, stat_valid_o, stat_par_o, stat_self_init_o, chain_sup_o;
    logic cuend_pend_o, sel_allow_o, got, got_self;
    // Tied off: test I/O, data-transfer ends and unusual conditions are out of scope here
    logic sel_tio_i = 1'b0, op_active_i = 1'b0, chend_ev_i = 1'b0, devend_ev_i = 1'b0, unusual_i = 1'b0;
    logic [ADDR_W-1:0] sel_addr_i, op_addr_i, free_addr_i, stat_addr_o, got_addr;
    logic [STAT_W-1:0] stat_byte_o, got_byte;
    logic [3:0]        dly;
    logic [31:0]       rs = 32'h00002BFB;
    int                errors, n_checks, i, j;
    cusm_status_ctrl uut (.*);
    cusm_chan_model u_chan (.clock_i(clock_i), .rst_n_i(rst_n_i), .stat_valid_i(stat_valid_o),
        .stat_byte_i(stat_byte_o), .stat_addr_i(stat_addr_o), .stat_self_i(stat_self_init_o), .delay_i(dly),
        .accept_o(stat_accept_i), .got_o(got), .got_byte_o(got_byte), .got_addr_o(got_addr), .got_self_o(got_self));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    function automatic logic [31:0] nxt_rand();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : nxt_rand
    function automatic logic [7:0] exp_addr(input logic self, input logic [7:0] b);
        // Selection address for answers; self-initiated: operation's device only when channel end or device end rides along, else a free address
        return !self ? sel_addr_i : ((chend_ev_i | devend_ev_i) ? op_addr_i : free_addr_i);
    endfunction : exp_addr
    task automatic test_done();
        $display("errors=%0d n_checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // ev = {sel, cu_busy, dev_busy, ready, special_end, retry, special_cond}; cu_busy stays as set
    task automatic go(input logic [6:0] ev, input logic [7:0] e, input logic [7:0] msk);
        int k;
        logic [31:0] r;
        {sel_req_i, cu_busy_i, dev_busy_i, ready_ev_i, special_end_i, retry_req_i, special_cond_i} = ev;
        r = nxt_rand();
        {sel_addr_i, op_addr_i, free_addr_i} = r[23:0];
        r = nxt_rand();
        dly = r[3:0];
        for (k = 0; k < 60 && got !== 1'b1; k++) begin
            @(posedge clock_i);
            #1;
        end
        if (got !== 1'b1) begin
            errors++;
            test_done();
        end
        chk(got_byte & msk, e);
        chk({7'h0, got_self}, {7'h0, !ev[6]});
        chk(got_addr, exp_addr(!ev[6], e));
        chk({7'h0, chain_sup_o}, {7'h0, e[BIT_CUEND] | e[BIT_BUSY]});
        #1;
        {sel_req_i, dev_busy_i, ready_ev_i, special_end_i, retry_req_i, special_cond_i} = '0;
        repeat (6) @(posedge clock_i);
        #2;
    endtask : go
    initial begin
        rst_n_i = 1'b0;
        {sel_req_i, cu_busy_i, dev_busy_i, ready_ev_i, special_end_i, retry_req_i, special_cond_i} = '0;
        {sel_addr_i, op_addr_i, free_addr_i, dly} = '0;
        repeat (4) @(posedge clock_i);
        #2;
        rst_n_i = 1'b1;
        go(7'h60, 8'h0A, 8'hFF);
        go(7'h60, 8'h0A, 8'hFF);
        go(7'h00, 8'h04, 8'hFF);
        for (j = 0; j < 12; j++) begin
            chk({7'h0, stat_valid_o}, 8'h00);
            chk({7'h0, sel_allow_o}, 8'h01);
            @(posedge clock_i);
        end
        chk({7'h0, cuend_pend_o}, 8'h00);
        #2;
        go(7'h60, 8'h0A, 8'hFF);
        go(7'h40, 8'h04, 8'hFF);
        go(7'h08, 8'hA1, 8'hFF);
        go(7'h04, 8'h22, 8'hFF);
        go(7'h02, 8'h52, 8'hDF);
        go(7'h01, 8'h02, 8'h02);
        for (i = 0; i < 6; i++) begin
            for (j = 0; j <= nxt_rand() % 3; j++) go(7'h60, 8'h0A, 8'hFF);
            go(7'h00, 8'h04, 8'hFF);
        end
        test_done();
    end
endmodule : cusm_status_ctrl_tb
